// ### logic/ptm_map.svh
/*
 * Register map, field positions, reset values and timing constants of the
 * power threshold monitor.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef PTM_MAP_SVH
`define PTM_MAP_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define PTM_OFS_CTRL 8'h00
`define PTM_OFS_THR 8'h04
`define PTM_OFS_DLY 8'h08
`define PTM_OFS_STAB 8'h0C
`define PTM_OFS_RATED 8'h10
`define PTM_OFS_POWER 8'h14
`define PTM_OFS_STAT 8'h18
`define PTM_OFS_IRQ 8'h1C
`define PTM_OFS_MASK 8'h20

// ********************************************************************
// Field positions
// ********************************************************************
`define PTM_CTRL_DIR 0
`define PTM_CTRL_OUTSEL 1
`define PTM_CTRL_INSEL 2
`define PTM_LO_LSB 0
`define PTM_HI_LSB 16
`define PTM_ST_OUT 0
`define PTM_ST_ACT 1
`define PTM_ST_STAB 2
`define PTM_ST_EN 3
`define PTM_IRQ_ON 0
`define PTM_IRQ_OFF 1
`define PTM_IRQ_BAD 2

// ********************************************************************
// Reset values and answers
// ********************************************************************
`define PTM_RST_CTRL 32'h0000_0000
`define PTM_RST_THR 32'h0000_0000
`define PTM_RST_DLY 32'h0000_0000
`define PTM_RST_STAB 32'h0000_0000
`define PTM_RST_RATED 32'h0000_0000
`define PTM_RESP_OKAY 2'h0
`define PTM_RESP_SLVERR 2'h2
`define PTM_PERCENT 32'h0000_0064

// ********************************************************************
// Timing: one second at the 250 MHz clock
// ********************************************************************
`define PTM_CLK_HZ 250000000
`define PTM_SECOND_NS 1000000000
`define PTM_CLK_NS 4

`endif

// ### logic/ptm_monitor.sv
/*
 * Power threshold monitor with AXI4-Lite registers, interrupt and one
 * threshold output.
 * Assumes a 250 MHz aclk, synchronous active-low reset, a power sample
 * in the aclk domain and an asynchronous enable pin.
 */
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_map.svh"

// Behaviour
// - Direction zero low power, else high
// - Enable input gates function when assigned
// - No output assigned: function unavailable
// - Low mode: below lower for delay, assert
// - Low mode: above upper for delay, release
// - Thresholds are percent of rated power
// - Delays counted in whole seconds
// - Zero or inconsistent thresholds disable function
// - Enable rise: stabilise, output held off
// - High mode: above upper on, below lower off
module ptm_monitor #(
    parameter int unsigned TICK_CYCLES =
        `PTM_SECOND_NS / `PTM_CLK_NS,
    parameter int unsigned DLY_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ptm_pkg::ptm_power_type power_in,
    input wire logic enable_pin,
    output logic threshold_out,
    output logic irq
);
    import ptm_pkg::*;

    // Refused at elaboration: the counters cannot serve these values
    if (TICK_CYCLES < 1 || DLY_W < 1 || DLY_W > 16) begin : g_bad_param
        $error("ptm_monitor: bad parameters");
    end

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [31:0] ctrl_q, thr_q, dly_q, stab_q, rated_q, mask_q;
    logic [31:0] power_q;
    logic [2:0] irq_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q, w_have_q;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic known(input logic [7:0] a);
        return a == `PTM_OFS_CTRL || a == `PTM_OFS_THR ||
            a == `PTM_OFS_DLY || a == `PTM_OFS_STAB ||
            a == `PTM_OFS_RATED || a == `PTM_OFS_POWER ||
            a == `PTM_OFS_STAT || a == `PTM_OFS_IRQ ||
            a == `PTM_OFS_MASK;
    endfunction

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    wire wr_ctrl = wr_go && awaddr_q == `PTM_OFS_CTRL;
    wire wr_thr = wr_go && awaddr_q == `PTM_OFS_THR;
    wire wr_dly = wr_go && awaddr_q == `PTM_OFS_DLY;
    wire wr_stab = wr_go && awaddr_q == `PTM_OFS_STAB;
    wire wr_rated = wr_go && awaddr_q == `PTM_OFS_RATED;
    wire wr_irq = wr_go && awaddr_q == `PTM_OFS_IRQ;
    wire wr_mask = wr_go && awaddr_q == `PTM_OFS_MASK;
    wire rd_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PTM_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_q && !aw_take;
            s_axi_wready <= !w_have_q && !w_take;
            if (aw_take) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known(awaddr_q) ? `PTM_RESP_OKAY
                    : `PTM_RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `PTM_RST_CTRL;
            thr_q <= `PTM_RST_THR;
            dly_q <= `PTM_RST_DLY;
            stab_q <= `PTM_RST_STAB;
            rated_q <= `PTM_RST_RATED;
            mask_q <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
            if (wr_thr) thr_q <= merge(thr_q, wdata_q, wstrb_q);
            if (wr_dly) dly_q <= merge(dly_q, wdata_q, wstrb_q);
            if (wr_stab) stab_q <= merge(stab_q, wdata_q, wstrb_q);
            if (wr_rated) rated_q <= merge(rated_q, wdata_q, wstrb_q);
            if (wr_mask) mask_q <= merge(mask_q, wdata_q, wstrb_q);
        end
    end

    // ****************************************************************
    // Enable pin synchroniser and power sample
    // ****************************************************************
    logic en_s1_q, en_s2_q, en_s3_q, en_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            en_s3_q <= 1'b0;
            en_q <= 1'b0;
            power_q <= 32'h0000_0000;
        end else begin
            en_s1_q <= enable_pin;
            en_s2_q <= en_s1_q;
            en_s3_q <= en_s2_q;
            if (en_s2_q == en_s3_q) en_q <= en_s3_q;
            if (power_in.valid) power_q <= power_in.watts;
        end
    end

    // ****************************************************************
    // Thresholds and comparisons
    // ****************************************************************
    logic [15:0] lo_pct, hi_pct;
    logic [47:0] pwr_scaled, lo_scaled, hi_scaled;
    assign lo_pct = thr_q[`PTM_LO_LSB +: 16];
    assign hi_pct = thr_q[`PTM_HI_LSB +: 16];
    // Compare power*100 with pct*rated, avoiding a divider
    assign pwr_scaled = 48'(power_q) * 48'(`PTM_PERCENT);
    assign lo_scaled = 48'(lo_pct) * 48'(rated_q);
    assign hi_scaled = 48'(hi_pct) * 48'(rated_q);
    wire below_lo = pwr_scaled < lo_scaled;
    wire above_hi = pwr_scaled > hi_scaled;
    wire dir_high = ctrl_q[`PTM_CTRL_DIR];
    wire thr_bad = lo_pct == 16'h0000 || hi_pct == 16'h0000
        || lo_pct >= hi_pct;
    wire out_assigned = ctrl_q[`PTM_CTRL_OUTSEL];
    wire gate_ok = !ctrl_q[`PTM_CTRL_INSEL] || en_q;
    wire func_on = out_assigned && !thr_bad && gate_ok;
    // Which side turns the output on or off depends on direction
    wire on_cond = dir_high ? above_hi : below_lo;
    wire off_cond = dir_high ? below_lo : above_hi;
    wire [15:0] on_dly = dir_high ? dly_q[31:16] : dly_q[15:0];
    wire [15:0] off_dly = dir_high ? dly_q[15:0] : dly_q[31:16];

    // ****************************************************************
    // Second tick and state machine
    // ****************************************************************
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [15:0] sec_q;
    ptm_state_type state_q, state_d;
    logic en_prev_q;
    wire en_rise = en_q && !en_prev_q && ctrl_q[`PTM_CTRL_INSEL];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_cnt_q == 32'(TICK_CYCLES - 1);
            tick_cnt_q <= tick_cnt_q == 32'(TICK_CYCLES - 1) ? 32'h0000_0000
                : tick_cnt_q + 32'h0000_0001;
        end
    end

    wire watch = state_q == PTM_IDLE ? on_cond
        : state_q == PTM_ACT ? off_cond : 1'b1;
    wire [15:0] limit = state_q == PTM_IDLE ? on_dly
        : state_q == PTM_ACT ? off_dly : stab_q[15:0];
    wire expired = sec_q >= limit;

    always_comb begin
        state_d = state_q;
        case (state_q)
            PTM_OFF: state_d = func_on ? PTM_IDLE : PTM_OFF;
            PTM_STAB: state_d = expired ? PTM_IDLE : PTM_STAB;
            PTM_IDLE: state_d = on_cond && expired ? PTM_ACT : PTM_IDLE;
            PTM_ACT: state_d = off_cond && expired ? PTM_IDLE : PTM_ACT;
            default: state_d = PTM_OFF;
        endcase
        if (!func_on) begin
            state_d = PTM_OFF;
        end else if (en_rise) begin
            state_d = PTM_STAB;
        end
    end

    wire state_chg = state_d != state_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= PTM_OFF;
            sec_q <= 16'h0000;
            en_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            en_prev_q <= en_q;
            if (state_chg || !watch) begin
                sec_q <= 16'h0000;
            end else if (tick_q && !expired) begin
                sec_q <= sec_q + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // Output, status and interrupt
    // ****************************************************************
    wire [2:0] ev = {func_on == 1'b0 && state_q != PTM_OFF,
        state_q == PTM_ACT && state_d == PTM_IDLE,
        state_q != PTM_ACT && state_d == PTM_ACT};
    wire [31:0] status = {28'h000_0000, func_on,
        state_q == PTM_STAB, state_q == PTM_ACT, threshold_out};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            threshold_out <= 1'b0;
            irq_q <= 3'b000;
            irq <= 1'b0;
        end else begin
            threshold_out <= state_d == PTM_ACT;
            // A new event wins over a clear in the same cycle
            irq_q <= (irq_q & ~(wr_irq ? wdata_q[2:0] : 3'b000)) | ev;
            irq <= |(irq_q & mask_q[2:0]);
        end
    end

    wire [31:0] rd_mux =
        s_axi_araddr == `PTM_OFS_CTRL ? ctrl_q :
        s_axi_araddr == `PTM_OFS_THR ? thr_q :
        s_axi_araddr == `PTM_OFS_DLY ? dly_q :
        s_axi_araddr == `PTM_OFS_STAB ? stab_q :
        s_axi_araddr == `PTM_OFS_RATED ? rated_q :
        s_axi_araddr == `PTM_OFS_POWER ? power_q :
        s_axi_araddr == `PTM_OFS_STAT ? status :
        s_axi_araddr == `PTM_OFS_IRQ ? {29'h0000_0000, irq_q} :
        s_axi_araddr == `PTM_OFS_MASK ? mask_q : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PTM_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_take;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= known(s_axi_araddr) ? `PTM_RESP_OKAY
                    : `PTM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/ptm_pkg.sv
/*
 * Types shared by the power threshold monitor.
 * Assumes the map header is available on the include path.
 */
package ptm_pkg;
    // Measured power sample and its strobe
    typedef struct packed {
        logic valid;
        logic [31:0] watts;
    } ptm_power_type;

    typedef enum logic [3:0] {
        PTM_OFF = 4'b0001,
        PTM_STAB = 4'b0010,
        PTM_IDLE = 4'b0100,
        PTM_ACT = 4'b1000
    } ptm_state_type;
endpackage

// ### sim/ptm_checker.sv
/* Concurrent checks on the monitor's bus handshakes and reset state.
   Assumes it is bound to ptm_monitor and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ptm_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic threshold_out,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata not held");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("rvalid late");
    sequence s_pair;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_b_lat;
        s_pair |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("bvalid timing");
    property p_w_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_busy: assert property (p_w_busy) else $error("write taken early");
    property p_ar_busy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_busy: assert property (p_ar_busy) else $error("read taken early");
    property p_rst;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("bus not idle after reset");
    property p_rdy;
        $rose(aresetn) |=> s_axi_awready && s_axi_wready && s_axi_arready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready missing after reset");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_out: cover property ($rose(threshold_out));
    c_irq: cover property ($rose(irq));
endmodule
bind ptm_monitor ptm_checker ptm_checker_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .threshold_out(threshold_out),
    .irq(irq));
`default_nettype wire

// ### sim/ptm_power_src.sv
/* Generator power meter model: one sample every PERIOD cycles.
   Assumes the monitor's aclk; level is the power the bench wants seen. */
`timescale 1ns/1ps
`default_nettype none
module ptm_power_src #(
    parameter int PERIOD = 3
) (
    input wire logic aclk,
    input wire logic [31:0] level,
    output var ptm_pkg::ptm_power_type power
);
    import ptm_pkg::*;
    int cnt = 0;
    initial power = '0;
    // Between samples the data toggle, so a stale value is never usable
    always @(posedge aclk) begin
        cnt <= (cnt + 1) % PERIOD;
        power.valid <= (cnt == 0);
        power.watts <= (cnt == 0) ? level : ~power.watts;
    end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
/* Bench: AXI4-Lite master, power source, queued result checks.
   Assumes ptm_pkg, ptm_power_src, ptm_checker and the monitor. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ptm_pkg::*;
    localparam int T = 20;
    logic aclk, aresetn, awv, wv, bready, arv, rready, en, tout, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, lvl;
    logic [1:0] bresp, rresp;
    logic [65:0] e;
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    ptm_power_type pwr;
    int fail_count = 0;
    int cmp_count = 0;
    ptm_power_src #(.PERIOD(3)) ptm_power_src_i (
        .aclk(aclk), .level(lvl), .power(pwr));
    ptm_monitor #(.TICK_CYCLES(T)) ptm_monitor_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_in(pwr),
        .enable_pin(en), .threshold_out(tout), .irq(irq));
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic close_out;
        $display("mismatches %0d compares %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp_v(input logic [31:0] g, x);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, g, x);
        end
    endtask
    task automatic cmp_p(input logic g, x);
        cmp_v({31'h0, g}, {31'h0, x});
    endtask
    task automatic tmo(input logic bad);
        if (bad) begin
            fail_count++;
            close_out();
        end
    endtask
    // Result watcher: oldest note first
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            e = rq.pop_front();
            cmp_v(rdata & e[63:32], e[31:0]);
            cmp_v({30'h0, rresp}, {30'h0, e[65:64]});
        end
        if (bvalid && bready)
            cmp_v({30'h0, bresp}, {30'h0, bq.pop_front()});
    end
    // Ready for answers stands from the request until the answer is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = 2'h0);
        int n;
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (bvalid && bready)
                break;
            if (awv && awready)
                awv <= 1'b0;
            if (wv && wready)
                wv <= 1'b0;
        end
        bready <= 1'b0;
        tmo(n >= 50);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic [31:0] m = 32'hffff_ffff,
                      input logic [1:0] r = 2'h0);
        int n;
        rq.push_back({r, m, x});
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (rvalid && rready)
                break;
            if (arv && arready)
                arv <= 1'b0;
        end
        rready <= 1'b0;
        tmo(n >= 50);
    endtask
    task automatic wait_out(input logic v, input int lo, hi);
        int n;
        for (n = 0; n < hi && tout !== v; n++)
            @(posedge aclk);
        cmp_p(n >= lo, 1'b1);
        tmo(tout !== v);
    endtask
    initial begin
        {aresetn, awv, wv, bready, arv, rready, en} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        lvl = 32'h0000_0190;
        void'($urandom(2));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'h00, 32'h0);
        rd(8'h24, 32'h0, 32'hffff_ffff, 2'h2);
        wr(8'h24, 32'hffff_ffff, 2'h2);
        rd(8'h14, 32'h0000_0190);
        wr(8'h10, 32'h0000_03e8);
        wr(8'h04, 32'h003c_0014);
        wr(8'h08, 32'h0003_0002);
        wr(8'h0c, 32'h0000_0002);
        wr(8'h20, 32'h0000_0005);
        wr(8'h00, 32'h0000_0006);
        lvl <= $urandom % 200;
        repeat (4 * T) @(posedge aclk);
        cmp_p(tout, 1'b0);
        en <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(8'h18, 32'hc, 32'hc);
        wait_out(1'b1, 2 * T - 20, 4 * T + 40);
        repeat (2) @(posedge aclk);
        cmp_p(irq, 1'b1);
        wr(8'h1c, 32'h1);
        repeat (2) @(posedge aclk);
        cmp_p(irq, 1'b0);
        lvl <= 32'h0000_0259 + $urandom % 301;
        repeat (T - 8) @(posedge aclk);
        lvl <= 32'h0000_0190;
        repeat (8) @(posedge aclk);
        lvl <= 32'h0000_0259 + $urandom % 301;
        wait_out(1'b0, 2 * T - 6, 3 * T + 40);
        cmp_p(irq, 1'b0);
        rd(8'h1c, 32'h2, 32'h2);
        lvl <= 32'h0000_0258;
        wr(8'h00, 32'h0000_0007);
        repeat (5 * T) @(posedge aclk);
        cmp_p(tout, 1'b0);
        lvl <= 32'h0000_0259;
        wait_out(1'b1, 2 * T - 6, 3 * T + 40);
        wr(8'h04, 32'h0014_003c);
        wait_out(1'b0, 0, 6);
        rd(8'h1c, 32'h4, 32'h4);
        wr(8'h04, 32'h003c_0000);
        rd(8'h18, 32'h0, 32'h8);
        wr(8'h04, 32'h003c_0014);
        wait_out(1'b1, T, 3 * T + 40);
        lvl <= $urandom % 200;
        wait_out(1'b0, T - 6, 2 * T + 40);
        wr(8'h00, 32'h0000_0005);
        rd(8'h18, 32'h0, 32'h8);
        wr(8'h00, 32'h0000_0007);
        en <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(8'h18, 32'h0, 32'h8);
        close_out();
    end
endmodule
`default_nettype wire
